/* rtl/disp_cmd_pkg.sv */
package disp_cmd_pkg;

  // command codes
  localparam logic [7:0] CMD_REVERSE = 8'hA6;
  localparam logic [7:0] CMD_MUX = 8'hA8;
  localparam logic [7:0] CMD_RAM_DIR = 8'hAD;
  localparam logic [7:0] CMD_PAGE = 8'hB0;
  localparam logic [7:0] CMD_SCAN = 8'hC0;
  localparam logic [7:0] CMD_OFFSET = 8'hD3;
  localparam logic [7:0] CMD_SW_RESET = 8'hE2;
  localparam logic [7:0] CMD_NOP = 8'hE3;
  localparam logic [7:0] CMD_LADDER = 8'hE9;

  // field positions and byte width
  localparam int SCAN_BIT = 3;
  localparam int LADDER_BIT = 7;
  localparam int BYTE_BITS = 8;

  // power-on values and the lowest accepted mux ratio
  localparam logic [6:0] MUX_RESET = 7'h40;
  localparam logic [6:0] MUX_MIN = 7'h02;
  localparam logic [2:0] PAGE_RESET = 3'h0;
  localparam logic [5:0] OFFSET_RESET = 6'h00;

  // busy is held for this many system clocks per applied byte
  localparam int BUSY_CYCLES = 2;

  // byte handed from the link domain
  typedef struct packed {
    logic is_data;
    logic [7:0] value;
  } link_byte_t;

  // configuration seen by the display engine
  typedef struct packed {
    logic reverse;
    logic [6:0] mux_ratio;
    logic vertical;
    logic [2:0] page;
    logic scan_remap;
    logic [5:0] offset;
    logic ladder_en;
  } disp_cfg_t;

endpackage : disp_cmd_pkg

/* rtl/serial_byte_rx.sv */
`timescale 1ns/100ps
`default_nettype none
// shifts bytes on the link clock and hands each across by a toggle
module serial_byte_rx
  import disp_cmd_pkg::*;
(
  // link side
  input wire logic link_clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic sda_i,
  input wire logic register_data_select_i,
  // system side
  input wire logic sys_clk_i,
  output link_byte_t byte_o,
  output logic byte_stb_o
);

  logic [6:0] shift_reg;
  logic [2:0] count_reg;
  link_byte_t hold_reg;
  logic toggle_reg;
  logic [2:0] sync_reg;

  wire last_bit = (count_reg == 3'h7);
  wire frame_rst = rst_i | cs_n_i;

  // bit count restarts as soon as select goes high; the link clock is
  // idle between frames, so a cut frame would otherwise leave stale bits
  always_ff @(posedge link_clk_i or posedge frame_rst) begin
    if (frame_rst) begin
      count_reg <= 3'h0;
    end else begin
      count_reg <= count_reg + 3'h1;
    end
  end

  // msb first; holding word only written on the eighth bit, so it is
  // stable for at least two system clocks before the toggle is seen there
  always_ff @(posedge link_clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_reg <= 7'h00;
      hold_reg <= '0;
      toggle_reg <= 1'b0;
    end else if (!cs_n_i) begin
      shift_reg <= {shift_reg[5:0], sda_i};
      if (last_bit) begin
        hold_reg <= '{is_data: register_data_select_i,
                      value: {shift_reg, sda_i}};
        toggle_reg <= ~toggle_reg;
      end
    end
  end

  // toggle synchroniser; stage 0 is read only by stage 1
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_reg <= 3'h0;
      byte_stb_o <= 1'b0;
      byte_o <= '0;
    end else begin
      sync_reg <= {sync_reg[1:0], toggle_reg};
      byte_stb_o <= sync_reg[2] ^ sync_reg[1];
      byte_o <= hold_reg;
    end
  end

endmodule : serial_byte_rx
`default_nettype wire

/* rtl/disp_cmd_decoder.sv */
`timescale 1ns/100ps
`default_nettype none
// command decoder for the later commands of the display controller
module disp_cmd_decoder
  import disp_cmd_pkg::*;
(
  // system
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic reset_n_i,
  // serial link
  input wire logic link_clk_i,
  input wire logic cs_n_i,
  input wire logic sda_i,
  input wire logic register_data_select_i,
  // status and configuration
  output logic busy_o,
  output disp_cfg_t cfg_o,
  output logic [7:0] ram_data_o,
  output logic ram_data_stb_o
);

  typedef enum logic [2:0] {
    WAIT_CMD, WAIT_MUX, WAIT_DIR, WAIT_OFFSET, WAIT_LADDER
  } param_state_t;

  logic [1:0] pin_rst_sync_reg;
  logic rst_int;
  link_byte_t rx_byte;
  logic rx_stb;
  param_state_t state_reg, state_next;
  disp_cfg_t cfg_next;
  logic [1:0] busy_cnt_reg;

  // reset pin passes two flops; released synchronously
  always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      pin_rst_sync_reg <= 2'b00;
    end else begin
      pin_rst_sync_reg <= {pin_rst_sync_reg[0], reset_n_i};
    end
  end
  assign rst_int = sys_rst_i | ~pin_rst_sync_reg[1];

  serial_byte_rx u_rx (
    .link_clk_i(link_clk_i),
    .rst_i(rst_int),
    .cs_n_i(cs_n_i),
    .sda_i(sda_i),
    .register_data_select_i(register_data_select_i),
    .sys_clk_i(sys_clk_i),
    .byte_o(rx_byte),
    .byte_stb_o(rx_stb)
  );

  // byte classification
  wire [7:0] b = rx_byte.value;
  wire is_cmd = rx_stb & ~rx_byte.is_data;
  wire is_page = (b[7:3] == CMD_PAGE[7:3]);
  wire is_scan = ({b[7:4], b[2:0]} == {CMD_SCAN[7:4], CMD_SCAN[2:0]});
  wire is_rev = (b[7:1] == CMD_REVERSE[7:1]);
  wire [6:0] mux_val = b[6:0];
  wire mux_ok = (mux_val >= MUX_MIN) && (mux_val <= MUX_RESET);
  // codes decoded here; anything else is left alone, like the no-op
  wire is_param_cmd = (b == CMD_MUX) || (b == CMD_RAM_DIR) ||
    (b == CMD_OFFSET) || (b == CMD_LADDER);
  wire is_known = is_param_cmd || is_page || is_scan || is_rev ||
    (b == CMD_SW_RESET);

  // decode; a pending parameter takes the byte first
  always_comb begin
    state_next = state_reg;
    cfg_next = cfg_o;
    if (is_cmd) begin
      state_next = WAIT_CMD;
      unique case (state_reg)
        WAIT_MUX: begin
          if (mux_ok) cfg_next.mux_ratio = mux_val;
        end
        WAIT_DIR: cfg_next.vertical = b[0];
        WAIT_OFFSET: cfg_next.offset = b[5:0];
        WAIT_LADDER: cfg_next.ladder_en = b[LADDER_BIT];
        WAIT_CMD: begin
          if (b == CMD_MUX) state_next = WAIT_MUX;
          else if (b == CMD_RAM_DIR) state_next = WAIT_DIR;
          else if (b == CMD_OFFSET) state_next = WAIT_OFFSET;
          else if (b == CMD_LADDER) state_next = WAIT_LADDER;
          else if (is_page) cfg_next.page = b[2:0];
          else if (is_scan) cfg_next.scan_remap = b[SCAN_BIT];
          else if (is_rev) cfg_next.reverse = b[0];
          else if (b == CMD_SW_RESET) begin
            cfg_next = '{reverse: 1'b0, mux_ratio: MUX_RESET,
                         vertical: 1'b0, page: PAGE_RESET,
                         scan_remap: 1'b0, offset: OFFSET_RESET,
                         ladder_en: 1'b0};
          end
          // no-op and unknown codes fall through untouched
        end
        default: state_next = WAIT_CMD;
      endcase
    end
  end

  // configuration and parameter state
  always_ff @(posedge sys_clk_i or posedge rst_int) begin
    if (rst_int) begin
      state_reg <= WAIT_CMD;
      cfg_o <= '{reverse: 1'b0, mux_ratio: MUX_RESET, vertical: 1'b0,
                 page: PAGE_RESET, scan_remap: 1'b0,
                 offset: OFFSET_RESET, ladder_en: 1'b0};
    end else begin
      state_reg <= state_next;
      cfg_o <= cfg_next;
    end
  end

  // display data is routed out, not decoded
  always_ff @(posedge sys_clk_i or posedge rst_int) begin
    if (rst_int) begin
      ram_data_o <= 8'h00;
      ram_data_stb_o <= 1'b0;
    end else begin
      ram_data_stb_o <= rx_stb & rx_byte.is_data;
      if (rx_stb & rx_byte.is_data) ram_data_o <= b;
    end
  end

  // busy while applying a byte or held in reset
  // a byte still crossing from the link does not raise busy yet
  wire [1:0] busy_cnt_next = rx_stb ? 2'(BUSY_CYCLES)
    : (busy_cnt_reg != 2'h0) ? busy_cnt_reg - 2'h1 : 2'h0;
  always_ff @(posedge sys_clk_i or posedge rst_int) begin
    if (rst_int) begin
      busy_cnt_reg <= 2'h0;
      busy_o <= 1'b1;
    end else begin
      busy_cnt_reg <= busy_cnt_next;
      busy_o <= (busy_cnt_next != 2'h0);
    end
  end

  // parameter and command-field loads
  mux_load_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_int) is_cmd && state_reg == WAIT_MUX && mux_ok |=>
    cfg_o.mux_ratio == $past(mux_val)) else $error("ratio not loaded");
  mux_range_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_int) cfg_o.mux_ratio >= MUX_MIN &&
    cfg_o.mux_ratio <= MUX_RESET) else $error("ratio out of range");
  mux_refuse_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_int) is_cmd && state_reg == WAIT_MUX && !mux_ok |=>
    $stable(cfg_o)) else $error("bad ratio accepted");
  dir_load_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_int) is_cmd && state_reg == WAIT_DIR |=>
    cfg_o.vertical == $past(b[0])) else $error("direction not loaded");
  page_load_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_int) is_cmd && state_reg == WAIT_CMD && is_page |=>
    cfg_o.page == $past(b[2:0])) else $error("page not loaded");
  scan_load_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_int) is_cmd && state_reg == WAIT_CMD && is_scan |=>
    cfg_o.scan_remap == $past(b[3])) else $error("scan not loaded");
  offset_load_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_int) is_cmd && state_reg == WAIT_OFFSET |=>
    cfg_o.offset == $past(b[5:0])) else $error("offset not loaded");
  ladder_load_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_int) is_cmd && state_reg == WAIT_LADDER |=>
    cfg_o.ladder_en == $past(b[7])) else $error("ladder not loaded");
  rev_load_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_int) is_cmd && state_reg == WAIT_CMD && is_rev |=>
    cfg_o.reverse == $past(b[0])) else $error("polarity not loaded");

  // data routing and busy
  data_route_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_int) rx_stb && rx_byte.is_data |=>
    ram_data_stb_o && $stable(cfg_o)) else $error("data byte misrouted");
  data_value_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_int) rx_stb && rx_byte.is_data |=>
    ram_data_o == $past(b)) else $error("data byte lost");
  ram_keep_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_int) !(rx_stb && rx_byte.is_data) |=>
    $stable(ram_data_o)) else $error("data output changed");
  cmd_no_data_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_int) is_cmd |=> !ram_data_stb_o)
    else $error("command sent as data");
  cfg_quiet_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_int) !is_cmd |=> $stable(cfg_o))
    else $error("config changed without command");
  stb_single_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_int) ram_data_stb_o |=> !ram_data_stb_o)
    else $error("data strobe too long");
  busy_hold_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_int) rx_stb |=> busy_o [*2] ##1 (!busy_o ||
    $past(rx_stb) || $past(rx_stb, 2))) else $error("busy wrong length");
  busy_rise_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_int) $rose(busy_o) |-> $past(rx_stb))
    else $error("busy rose without a byte");
  pin_reset_a: assert property (@(posedge sys_clk_i)
    disable iff (sys_rst_i) !pin_rst_sync_reg[1] |=> busy_o &&
    cfg_o.mux_ratio == MUX_RESET) else $error("pin reset not applied");

  // parameter sequencing and power-on values
  param_enter_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_int) is_cmd && state_reg == WAIT_CMD && is_param_cmd
    |=> state_reg != WAIT_CMD && $stable(cfg_o))
    else $error("parameter command not held");
  param_take_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_int) is_cmd && state_reg != WAIT_CMD |=>
    state_reg == WAIT_CMD) else $error("parameter decoded as command");
  param_keep_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_int) rx_stb && rx_byte.is_data |=> $stable(state_reg))
    else $error("data byte took the parameter");
  param_only_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_int) is_cmd && state_reg != WAIT_CMD |=>
    cfg_o.page == $past(cfg_o.page) && cfg_o.reverse ==
    $past(cfg_o.reverse) && cfg_o.scan_remap == $past(cfg_o.scan_remap))
    else $error("parameter touched a command field");
  sw_reset_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_int) is_cmd && state_reg == WAIT_CMD &&
    b == CMD_SW_RESET |=> cfg_o.mux_ratio == MUX_RESET &&
    cfg_o.page == PAGE_RESET && cfg_o.offset == OFFSET_RESET &&
    !cfg_o.ladder_en && !cfg_o.reverse && !cfg_o.vertical &&
    !cfg_o.scan_remap) else $error("soft reset incomplete");
  nop_still_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_int) is_cmd && state_reg == WAIT_CMD && b == CMD_NOP
    |=> $stable(cfg_o)) else $error("no-op changed state");
  unknown_still_a: assert property (@(posedge sys_clk_i)
    disable iff (rst_int) is_cmd && state_reg == WAIT_CMD && !is_known
    |=> $stable(cfg_o) && state_reg == WAIT_CMD)
    else $error("unknown code changed state");

endmodule : disp_cmd_decoder
`default_nettype wire

/* test/host_link_model.sv */
`timescale 1ns/100ps
`default_nettype none
// host end of the serial write link; its clock runs only inside frames
module host_link_model
  import disp_cmd_pkg::*;
(
  // link pins
  output logic link_clk_o,
  output logic cs_n_o,
  output logic sda_o,
  output logic sel_o
);
  initial begin
    link_clk_o = 1'b0;
    cs_n_o = 1'b1;
    sda_o = 1'b1;
    sel_o = 1'b1;
  end
  // whole byte msb first, select held for the full frame
  task automatic send(input link_byte_t b);
    #7;
    sel_o = b.is_data;
    cs_n_o = 1'b0;
    for (int i = BYTE_BITS - 1; i >= 0; i--) begin
      sda_o = b.value[i];
      #24 link_clk_o = 1'b1;
      #24 link_clk_o = 1'b0;
    end
    #12 cs_n_o = 1'b1;
    // released lines flip so a stale value is never mistaken for data
    sda_o = ~sda_o;
    sel_o = ~sel_o;
  endtask : send
  // frame cut short after n bits; the receiver must drop them
  task automatic cut(input int n);
    #7;
    sel_o = 1'b0;
    cs_n_o = 1'b0;
    for (int i = 0; i < n; i++) begin
      sda_o = 1'b1;
      #24 link_clk_o = 1'b1;
      #24 link_clk_o = 1'b0;
    end
    #12 cs_n_o = 1'b1;
    sda_o = ~sda_o;
    sel_o = ~sel_o;
  endtask : cut
endmodule : host_link_model
`default_nettype wire

/* test/display_cmd_decoder_tail_test.sv */
`timescale 1ns/100ps
`default_nettype none
module display_cmd_decoder_tail_test
  import disp_cmd_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic reset_n_i = 1'b1;
  logic link_clk, cs_n, sda, sel, busy, stb;
  logic [7:0] ram;
  disp_cfg_t cfg, exp, por;
  int n_fail = 0;
  int n_checks = 0;
  int n_stb = 0;
  disp_cmd_decoder u_disp_cmd_decoder (.sys_clk_i(sys_clk_i),
    .sys_rst_i(sys_rst_i), .reset_n_i(reset_n_i), .link_clk_i(link_clk),
    .cs_n_i(cs_n), .sda_i(sda), .register_data_select_i(sel),
    .busy_o(busy), .cfg_o(cfg), .ram_data_o(ram), .ram_data_stb_o(stb));
  host_link_model u_host_link_model (.link_clk_o(link_clk), .cs_n_o(cs_n),
    .sda_o(sda), .sel_o(sel));
  // system clock, 100 ns period
  always #50 sys_clk_i = ~sys_clk_i;
  // count data strobes, each is a single-cycle pulse
  always @(posedge sys_clk_i) if (stb === 1'b1) n_stb <= n_stb + 1;
  task automatic check(input string w, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask : check
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : end_of_test
  // bounded wait for busy to fall before the next byte
  task automatic idle;
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 50) begin
      @(negedge sys_clk_i);
      k++;
    end
    if (busy !== 1'b0) begin
      n_fail++;
      end_of_test();
    end
  endtask : idle
  task automatic put(input logic d, input logic [7:0] v);
    int k;
    @(negedge sys_clk_i);
    u_host_link_model.send('{is_data: d, value: v});
    k = 0;
    while (busy !== 1'b1 && k < 10) begin
      @(negedge sys_clk_i);
      k++;
    end
    check("busy after byte", 1, busy);
    idle();
  endtask : put
  task automatic cmd(input logic [7:0] v);
    put(1'b0, v);
    check("cfg", exp, cfg);
  endtask : cmd
  task automatic dat(input logic [7:0] v);
    int n0;
    n0 = n_stb;
    put(1'b1, v);
    check("ram data", v, ram);
    check("strobes", n0 + 1, n_stb);
    check("cfg", exp, cfg);
  endtask : dat
  task automatic t_mux;
    logic [7:0] p [6] = '{8'h20, 8'h41, 8'h01, 8'h02, 8'hA0, 8'h40};
    foreach (p[i]) begin
      cmd(CMD_MUX);
      if (p[i][6:0] >= MUX_MIN && p[i][6:0] <= MUX_RESET)
        exp.mux_ratio = p[i][6:0];
      cmd(p[i]);
    end
    cmd(CMD_MUX);
    dat(8'h5A);
    exp.mux_ratio = 7'h10;
    cmd(8'h10);
    $display("done mux");
  endtask : t_mux
  task automatic t_fields;
    cmd(CMD_RAM_DIR);
    exp.vertical = 1'b1;
    cmd(8'h01);
    cmd(CMD_RAM_DIR);
    exp.vertical = 1'b0;
    cmd(8'h00);
    for (int i = 7; i >= 0; i--) begin
      exp.page = i[2:0];
      cmd(CMD_PAGE | i[7:0]);
    end
    exp.scan_remap = 1'b1;
    cmd(CMD_SCAN | 8'h08);
    exp.scan_remap = 1'b0;
    cmd(CMD_SCAN);
    $display("done fields");
  endtask : t_fields
  task automatic t_offset;
    cmd(CMD_OFFSET);
    exp.offset = 6'h27;
    cmd(8'hA7);
    cmd(CMD_OFFSET);
    exp.offset = 6'h03;
    cmd(8'h03);
    cmd(CMD_MUX);
    exp.mux_ratio = 7'h30;
    cmd(8'h30);
    cmd(CMD_OFFSET);
    exp.offset = 6'h30;
    cmd(8'h40 - 8'h10);
    $display("done offset");
  endtask : t_offset
  task automatic t_bits;
    for (int i = 0; i < 3; i++) begin
      cmd(CMD_LADDER);
      exp.ladder_en = ~i[0];
      cmd({~i[0], 7'h04});
      exp.reverse = ~i[0];
      cmd(CMD_REVERSE | {7'h00, ~i[0]});
    end
    cmd(CMD_NOP);
    cmd(8'hE0);
    exp = por;
    cmd(CMD_SW_RESET);
    $display("done bits");
  endtask : t_bits
  task automatic t_pin;
    exp.reverse = 1'b1;
    cmd(CMD_REVERSE | 8'h01);
    reset_n_i = 1'b0;
    repeat (6) @(negedge sys_clk_i);
    check("busy pin reset", 1, busy);
    check("cfg pin reset", por, cfg);
    reset_n_i = 1'b1;
    exp = por;
    repeat (4) @(negedge sys_clk_i);
    idle();
    cmd(CMD_NOP);
    $display("done pin");
  endtask : t_pin
  // a cut frame must leave no bits behind for the next byte
  task automatic t_cut;
    @(negedge sys_clk_i);
    u_host_link_model.cut(3);
    repeat (10) @(negedge sys_clk_i);
    check("busy after cut", 0, busy);
    check("cfg after cut", exp, cfg);
    exp.page = 3'h5;
    cmd(CMD_PAGE | 8'h05);
    $display("done cut");
  endtask : t_cut
  // main sequence
  initial begin
    por = '{1'b0, MUX_RESET, 1'b0, PAGE_RESET, 1'b0, OFFSET_RESET, 1'b0};
    exp = por;
    repeat (6) @(negedge sys_clk_i);
    check("busy in reset", 1, busy);
    check("cfg in reset", por, cfg);
    sys_rst_i = 1'b0;
    idle();
    t_mux();
    t_fields();
    t_offset();
    t_bits();
    t_pin();
    t_cut();
    end_of_test();
  end
endmodule : display_cmd_decoder_tail_test
`default_nettype wire
